// [design/ffab_pkg.sv]
// Constants and types for the fault flag acknowledge bank.
// Summary of operation
// - First system error flag register sits at offset 05, eight bits, resets zero.
// - Flags read one once detected; writing one clears a flag unless its event is still active; reset zero.
// - Bit 7 of first error register latches forced reset power-down completion.
// - Bit 6 of first error register latches input undervoltage lockout.
// - Bit 5 of first error register latches thermal shutdown.
// - Bit 3 latches input overvoltage error, only when the OTP option enables it.
// - Bit 2 of first error register latches automatic re-arm error.
// - Bit 1 of first error register latches register write CRC failure.
// - Bit 0 latches self-test failure or uncorrectable OTP ECC fault.
// - Short flags at offset 06: switch shorts 6..4, linreg 3, outputs 2..0.
// - Overvoltage flags at offset 07: linreg bit 3, converters bits 2..0.
// - Undervoltage flags at offset 08: linreg bit 3, converters bits 2..0.
// - Overcurrent flags at offset 09; bit 6 linreg overcurrent, bit 7 unused.
// - Overcurrent bits 5, 3, 1 latch negative limit of converters 3, 2, 1.
// - Overcurrent bits 4, 2, 0 latch peak limit of converters 3, 2, 1.
// - Status register at 03 ORs unmasked flags of each flag register.
package ffab_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_SYS_ERR = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_SHORT = 8'h06;
    localparam logic [ADDR_W-1:0] OFS_OV_MON = 8'h07;
    localparam logic [ADDR_W-1:0] OFS_UV_MON = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OC = 8'h09;

    localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;

    // Implemented bit positions of each flag register.
    localparam logic [DATA_W-1:0] USED_SYS_ERR = 8'hEF;
    localparam logic [DATA_W-1:0] USED_SHORT = 8'h7F;
    localparam logic [DATA_W-1:0] USED_MON = 8'h0F;
    localparam logic [DATA_W-1:0] USED_OC = 8'h7F;

    // Bit positions inside the system error register.
    localparam int BIT_FORCED_RESET = 7;
    localparam int BIT_UVLO = 6;
    localparam int BIT_TSD = 5;
    localparam int BIT_IN_OVERVOLT = 3;
    localparam int BIT_AUTO_REARM = 2;
    localparam int BIT_WRITE_CRC = 1;
    localparam int BIT_SELF_TEST = 0;

    // Bit positions inside the short circuit register.
    localparam int SC_SW_C3 = 6;
    localparam int SC_SW_C2 = 5;
    localparam int SC_SW_C1 = 4;
    localparam int SC_LINREG = 3;
    localparam int SC_OUT_C3 = 2;
    localparam int SC_OUT_C2 = 1;
    localparam int SC_OUT_C1 = 0;

    // Bit positions shared by both voltage monitor registers.
    localparam int MON_LINREG = 3;
    localparam int MON_C3 = 2;
    localparam int MON_C2 = 1;
    localparam int MON_C1 = 0;

    // Bit positions inside the overcurrent register.
    localparam int OC_LINREG = 6;
    localparam int OC_NEG_C3 = 5;
    localparam int OC_PEAK_C3 = 4;
    localparam int OC_NEG_C2 = 3;
    localparam int OC_PEAK_C2 = 2;
    localparam int OC_NEG_C1 = 1;
    localparam int OC_PEAK_C1 = 0;

    // Summary bit positions of the status register.
    localparam int ST_OC_BIT = 5;
    localparam int ST_UV_BIT = 3;
    localparam int ST_OV_BIT = 2;
    localparam int ST_ERR_BIT = 1;

    typedef logic [DATA_W-1:0] ffab_byte_t;
    typedef logic [ADDR_W-1:0] ffab_addr_t;

endpackage

// [design/ffab_flag_bank.sv]
// One eight-bit sticky flag register with write-one-to-clear access.
`timescale 1ns/1ps
module ffab_flag_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] USED = '1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Asynchronous event levels and same-clock qualifiers.
    input wire logic [WIDTH-1:0] event_raw,
    input wire logic [WIDTH-1:0] event_qual,
    // Clearing write.
    input wire logic clear_en,
    input wire logic [WIDTH-1:0] clear_data,
    // Latched flags.
    output logic [WIDTH-1:0] flags
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] flags;
    } ffab_bank_s;

    ffab_bank_s st_reg;
    ffab_bank_s st_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("ffab_flag_bank: WIDTH must be at least one");
    end

    always_comb begin
        logic [WIDTH-1:0] agree;
        logic [WIDTH-1:0] set_v;
        logic [WIDTH-1:0] clr_v;
        agree = ~(st_reg.s2 ^ st_reg.s3);
        set_v = st_reg.level & event_qual & USED;
        clr_v = clear_en ? (clear_data & USED) : '0;
        st_next = st_reg;
        st_next.s1 = event_raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // A level change counts once the second and third stages agree.
        st_next.level = (st_reg.s2 & agree) | (st_reg.level & ~agree);
        st_next.flags = ((st_reg.flags & ~clr_v) | set_v) & USED;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.flags <= RESET_VAL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;

endmodule

// [design/ffab_top.sv]
// Fault flag acknowledge bank: five sticky flag registers and a status summary.
`timescale 1ns/1ps
module ffab_top
    import ffab_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Register port from the serial control interface.
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire ffab_pkg::ffab_addr_t reg_addr,
    input wire ffab_pkg::ffab_byte_t reg_wdata,
    output ffab_pkg::ffab_byte_t reg_rdata,
    output logic reg_rd_valid,
    output logic reg_wr_done,
    // Mask bits from the mask registers, one means masked.
    input wire ffab_pkg::ffab_byte_t sys_err_mask,
    input wire ffab_pkg::ffab_byte_t short_mask,
    input wire ffab_pkg::ffab_byte_t ov_mon_mask,
    input wire ffab_pkg::ffab_byte_t uv_mon_mask,
    input wire ffab_pkg::ffab_byte_t oc_mask,
    // One-time-programmed option enabling the input overvoltage error.
    input wire logic otp_in_overvolt_en,
    // System events.
    input wire logic forced_reset_done_flag,
    input wire logic input_undervolt_lockout_flag,
    input wire logic thermal_shutdown_flag,
    input wire logic input_overvolt_error_flag,
    input wire logic auto_rearm_error_flag,
    input wire logic write_crc_error_flag,
    input wire logic self_test_error_flag,
    input wire logic otp_ecc_error_event,
    // Short circuit events.
    input wire logic conv3_switch_short_flag,
    input wire logic conv2_switch_short_flag,
    input wire logic conv1_switch_short_flag,
    input wire logic linreg_short_flag,
    input wire logic conv3_output_short_flag,
    input wire logic conv2_output_short_flag,
    input wire logic conv1_output_short_flag,
    // Overvoltage monitor events.
    input wire logic linreg_overvolt_flag,
    input wire logic conv3_overvolt_flag,
    input wire logic conv2_overvolt_flag,
    input wire logic conv1_overvolt_flag,
    // Undervoltage monitor events.
    input wire logic linreg_undervolt_flag,
    input wire logic conv3_undervolt_flag,
    input wire logic conv2_undervolt_flag,
    input wire logic conv1_undervolt_flag,
    // Overcurrent events.
    input wire logic linreg_overcurrent_flag,
    input wire logic conv3_negative_limit_flag,
    input wire logic conv3_peak_limit_flag,
    input wire logic conv2_negative_limit_flag,
    input wire logic conv2_peak_limit_flag,
    input wire logic conv1_negative_limit_flag,
    input wire logic conv1_peak_limit_flag,
    // Summary status and latched flags.
    output ffab_pkg::ffab_byte_t status_summary,
    output ffab_pkg::ffab_byte_t sys_err_flags,
    output ffab_pkg::ffab_byte_t short_flags,
    output ffab_pkg::ffab_byte_t ov_mon_flags,
    output ffab_pkg::ffab_byte_t uv_mon_flags,
    output ffab_pkg::ffab_byte_t oc_flags
);

    import ffab_pkg::*;

    // The bank and the register map assume byte-wide flag registers.
    if (DATA_W != 8) begin : g_bad_data_w
        $error("ffab_top: DATA_W must be eight");
    end
    if (ADDR_W < 4) begin : g_bad_addr_w
        $error("ffab_top: ADDR_W too narrow for the register map");
    end

    ////////////////////////////////////////////////////////////////////////
    // Event vectors.

    ffab_byte_t sys_err_raw;
    ffab_byte_t short_raw;
    ffab_byte_t ov_mon_raw;
    ffab_byte_t uv_mon_raw;
    ffab_byte_t oc_raw;
    ffab_byte_t sys_err_qual;

    always_comb begin
        sys_err_raw = '0;
        sys_err_raw[BIT_FORCED_RESET] = forced_reset_done_flag;
        sys_err_raw[BIT_UVLO] = input_undervolt_lockout_flag;
        sys_err_raw[BIT_TSD] = thermal_shutdown_flag;
        sys_err_raw[BIT_IN_OVERVOLT] = input_overvolt_error_flag;
        sys_err_raw[BIT_AUTO_REARM] = auto_rearm_error_flag;
        sys_err_raw[BIT_WRITE_CRC] = write_crc_error_flag;
        sys_err_raw[BIT_SELF_TEST] = self_test_error_flag
            | otp_ecc_error_event;
    end

    always_comb begin
        sys_err_qual = '1;
        sys_err_qual[BIT_IN_OVERVOLT] = otp_in_overvolt_en;
    end

    always_comb begin
        short_raw = '0;
        short_raw[SC_SW_C3] = conv3_switch_short_flag;
        short_raw[SC_SW_C2] = conv2_switch_short_flag;
        short_raw[SC_SW_C1] = conv1_switch_short_flag;
        short_raw[SC_LINREG] = linreg_short_flag;
        short_raw[SC_OUT_C3] = conv3_output_short_flag;
        short_raw[SC_OUT_C2] = conv2_output_short_flag;
        short_raw[SC_OUT_C1] = conv1_output_short_flag;
    end

    always_comb begin
        ov_mon_raw = '0;
        ov_mon_raw[MON_LINREG] = linreg_overvolt_flag;
        ov_mon_raw[MON_C3] = conv3_overvolt_flag;
        ov_mon_raw[MON_C2] = conv2_overvolt_flag;
        ov_mon_raw[MON_C1] = conv1_overvolt_flag;
    end

    always_comb begin
        uv_mon_raw = '0;
        uv_mon_raw[MON_LINREG] = linreg_undervolt_flag;
        uv_mon_raw[MON_C3] = conv3_undervolt_flag;
        uv_mon_raw[MON_C2] = conv2_undervolt_flag;
        uv_mon_raw[MON_C1] = conv1_undervolt_flag;
    end

    always_comb begin
        oc_raw = '0;
        oc_raw[OC_LINREG] = linreg_overcurrent_flag;
        oc_raw[OC_NEG_C3] = conv3_negative_limit_flag;
        oc_raw[OC_NEG_C2] = conv2_negative_limit_flag;
        oc_raw[OC_NEG_C1] = conv1_negative_limit_flag;
        oc_raw[OC_PEAK_C3] = conv3_peak_limit_flag;
        oc_raw[OC_PEAK_C2] = conv2_peak_limit_flag;
        oc_raw[OC_PEAK_C1] = conv1_peak_limit_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode.

    logic clr_sys_err;
    logic clr_short;
    logic clr_ov_mon;
    logic clr_uv_mon;
    logic clr_oc;

    always_comb begin
        clr_sys_err = 1'h0;
        clr_short = 1'h0;
        clr_ov_mon = 1'h0;
        clr_uv_mon = 1'h0;
        clr_oc = 1'h0;
        if (reg_wr_en && reg_addr == OFS_SYS_ERR) begin
            clr_sys_err = 1'h1;
        end else if (reg_wr_en && reg_addr == OFS_SHORT) begin
            clr_short = 1'h1;
        end else if (reg_wr_en && reg_addr == OFS_OV_MON) begin
            clr_ov_mon = 1'h1;
        end else if (reg_wr_en && reg_addr == OFS_UV_MON) begin
            clr_uv_mon = 1'h1;
        end else if (reg_wr_en && reg_addr == OFS_OC) begin
            clr_oc = 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag registers.

    ffab_flag_bank #(
        .WIDTH(DATA_W),
        .USED(USED_SYS_ERR),
        .RESET_VAL(FLAG_RESET)
    ) u_sys_err (
        .mclk(mclk),
        .rst(rst),
        .event_raw(sys_err_raw),
        .event_qual(sys_err_qual),
        .clear_en(clr_sys_err),
        .clear_data(reg_wdata),
        .flags(sys_err_flags)
    );

    ffab_flag_bank #(
        .WIDTH(DATA_W),
        .USED(USED_SHORT),
        .RESET_VAL(FLAG_RESET)
    ) u_short (
        .mclk(mclk),
        .rst(rst),
        .event_raw(short_raw),
        .event_qual('1),
        .clear_en(clr_short),
        .clear_data(reg_wdata),
        .flags(short_flags)
    );

    ffab_flag_bank #(
        .WIDTH(DATA_W),
        .USED(USED_MON),
        .RESET_VAL(FLAG_RESET)
    ) u_ov_mon (
        .mclk(mclk),
        .rst(rst),
        .event_raw(ov_mon_raw),
        .event_qual('1),
        .clear_en(clr_ov_mon),
        .clear_data(reg_wdata),
        .flags(ov_mon_flags)
    );

    ffab_flag_bank #(
        .WIDTH(DATA_W),
        .USED(USED_MON),
        .RESET_VAL(FLAG_RESET)
    ) u_uv_mon (
        .mclk(mclk),
        .rst(rst),
        .event_raw(uv_mon_raw),
        .event_qual('1),
        .clear_en(clr_uv_mon),
        .clear_data(reg_wdata),
        .flags(uv_mon_flags)
    );

    ffab_flag_bank #(
        .WIDTH(DATA_W),
        .USED(USED_OC),
        .RESET_VAL(FLAG_RESET)
    ) u_oc (
        .mclk(mclk),
        .rst(rst),
        .event_raw(oc_raw),
        .event_qual('1),
        .clear_en(clr_oc),
        .clear_data(reg_wdata),
        .flags(oc_flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status summary, read data and access handshakes.

    typedef struct packed {
        ffab_byte_t status;
        ffab_byte_t rdata;
        logic rd_valid;
        logic wr_done;
    } ffab_top_s;

    ffab_top_s st_reg;
    ffab_top_s st_next;

    always_comb begin
        ffab_byte_t summ;
        summ = '0;
        summ[ST_OC_BIT] = |(oc_flags & ~oc_mask);
        summ[ST_UV_BIT] = |(uv_mon_flags & ~uv_mon_mask);
        summ[ST_OV_BIT] = |(ov_mon_flags & ~ov_mon_mask);
        summ[ST_ERR_BIT] = |(sys_err_flags & ~sys_err_mask)
            | |(short_flags & ~short_mask);
        st_next = st_reg;
        st_next.status = summ;
        st_next.rd_valid = reg_rd_en;
        st_next.wr_done = reg_wr_en;
        st_next.rdata = '0;
        // Unmapped addresses read as zero.
        if (reg_rd_en && reg_addr == OFS_STATUS) begin
            st_next.rdata = st_reg.status;
        end else if (reg_rd_en && reg_addr == OFS_SYS_ERR) begin
            st_next.rdata = sys_err_flags;
        end else if (reg_rd_en && reg_addr == OFS_SHORT) begin
            st_next.rdata = short_flags;
        end else if (reg_rd_en && reg_addr == OFS_OV_MON) begin
            st_next.rdata = ov_mon_flags;
        end else if (reg_rd_en && reg_addr == OFS_UV_MON) begin
            st_next.rdata = uv_mon_flags;
        end else if (reg_rd_en && reg_addr == OFS_OC) begin
            st_next.rdata = oc_flags;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign status_summary = st_reg.status;
    assign reg_rdata = st_reg.rdata;
    assign reg_rd_valid = st_reg.rd_valid;
    assign reg_wr_done = st_reg.wr_done;

endmodule

// [tb/ffab_top_sva.sv]
// Concurrent checks on the fault flag bank ports.
`timescale 1ns/1ps
module ffab_top_sva (
    // Clock, reset and register port.
    input logic mclk,
    input logic rst,
    input logic reg_wr_en,
    input logic reg_rd_en,
    input ffab_pkg::ffab_addr_t reg_addr,
    input ffab_pkg::ffab_byte_t reg_wdata,
    input ffab_pkg::ffab_byte_t reg_rdata,
    input logic reg_rd_valid,
    input logic reg_wr_done,
    // Events, masks, status and flags.
    input logic otp_in_overvolt_en,
    input logic thermal_shutdown_flag,
    input ffab_pkg::ffab_byte_t oc_mask,
    input ffab_pkg::ffab_byte_t status_summary,
    input ffab_pkg::ffab_byte_t sys_err_flags,
    input ffab_pkg::ffab_byte_t short_flags,
    input ffab_pkg::ffab_byte_t oc_flags
);
    import ffab_pkg::*;
    ffab_byte_t clr_sys;
    ffab_byte_t keep_sys;
    assign clr_sys = (reg_wr_en && reg_addr == OFS_SYS_ERR) ?
        reg_wdata : 8'h00;
    assign keep_sys = sys_err_flags & ~clr_sys;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Five quiet samples drain the event synchroniser.
    sequence ts_quiet;
        !thermal_shutdown_flag [*5];
    endsequence
    sequence otp_off;
        !otp_in_overvolt_en [*5];
    endsequence
    AST_RD_ANSWER: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe not answered");
    AST_WR_ANSWER: assert property (reg_wr_en |=> reg_wr_done)
        else $error("write strobe not answered");
    AST_RD_IDLE: assert property (
        !reg_rd_valid |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_RD_SYS: assert property (
        reg_rd_en && reg_addr == OFS_SYS_ERR |=>
        reg_rdata == $past(sys_err_flags))
        else $error("system error read returns wrong value");
    AST_RESET_ZERO: assert property (
        $past(rst) |-> sys_err_flags == 8'h00 && oc_flags == 8'h00 &&
        status_summary == 8'h00)
        else $error("flags not zero after reset");
    AST_UNUSED: assert property (
        (sys_err_flags & ~USED_SYS_ERR) == 8'h00 &&
        (short_flags & ~USED_SHORT) == 8'h00 &&
        (oc_flags & ~USED_OC) == 8'h00)
        else $error("unused flag bit set");
    AST_STATUS_OC: assert property (
        !$past(rst) |-> status_summary[ST_OC_BIT] ==
        |($past(oc_flags) & ~$past(oc_mask)))
        else $error("overcurrent summary wrong");
    AST_STICKY: assert property (
        1'h1 |=> ($past(keep_sys) & ~sys_err_flags) == 8'h00)
        else $error("flag dropped without clear");
    AST_CLEAR: assert property (
        ts_quiet ##0 clr_sys[BIT_TSD] |=> !sys_err_flags[BIT_TSD])
        else $error("write one did not clear flag");
    AST_OTP_GATE: assert property (
        otp_off ##0 !sys_err_flags[BIT_IN_OVERVOLT] |=>
        !sys_err_flags[BIT_IN_OVERVOLT])
        else $error("overvoltage error set while disabled");
endmodule
bind ffab_top ffab_top_sva chk_u (
    .mclk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rd_valid, .reg_wr_done, .otp_in_overvolt_en, .thermal_shutdown_flag,
    .oc_mask, .status_summary, .sys_err_flags, .short_flags, .oc_flags);

// [tb/ffab_host.sv]
// Host processor model driving the register port of the flag bank.
`timescale 1ns/1ps
module ffab_host (
    // Clock.
    input logic mclk,
    // Register port.
    output logic reg_wr_en,
    output logic reg_rd_en,
    output ffab_pkg::ffab_addr_t reg_addr,
    output ffab_pkg::ffab_byte_t reg_wdata,
    input ffab_pkg::ffab_byte_t reg_rdata,
    input logic reg_rd_valid,
    input logic reg_wr_done
);
    import ffab_pkg::*;
    initial begin
        reg_wr_en = 1'h0;
        reg_rd_en = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One request after gap idle cycles; address and data are scrambled
    // once taken so that nothing relies on stale values.
    task automatic req(input bit wr, input ffab_addr_t a,
            input ffab_byte_t d, input int gap, output ffab_byte_t q);
        q = 8'hXX;
        repeat (gap) @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= wr;
        reg_rd_en <= !wr;
        @(posedge mclk);
        reg_wr_en <= 1'h0;
        reg_rd_en <= 1'h0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        for (int n = 0; n < 4; n++) begin
            @(posedge mclk);
            if (reg_rd_valid || reg_wr_done) begin
                q = reg_rdata;
                break;
            end
        end
    endtask
endmodule

// [tb/ffab_top_test.sv]
// Self-checking bench for the fault flag bank.
`timescale 1ns/1ps
module ffab_top_test;
    import ffab_pkg::*;
    logic mclk;
    logic rst;
    logic otp;
    logic reg_wr_en;
    logic reg_rd_en;
    logic reg_rd_valid;
    logic reg_wr_done;
    ffab_addr_t reg_addr;
    ffab_byte_t reg_wdata;
    ffab_byte_t reg_rdata;
    ffab_byte_t status_summary;
    ffab_byte_t ev [5];
    ffab_byte_t mk [5];
    ffab_byte_t fl [5];
    ffab_byte_t xf [5];
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    ffab_top dut_u (
        .mclk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rd_valid, .reg_wr_done, .status_summary,
        .sys_err_mask(mk[0]), .short_mask(mk[1]), .ov_mon_mask(mk[2]),
        .uv_mon_mask(mk[3]), .oc_mask(mk[4]), .otp_in_overvolt_en(otp),
        .forced_reset_done_flag(ev[0][7]),
        .input_undervolt_lockout_flag(ev[0][6]),
        .thermal_shutdown_flag(ev[0][5]), .otp_ecc_error_event(ev[0][4]),
        .input_overvolt_error_flag(ev[0][3]),
        .auto_rearm_error_flag(ev[0][2]), .write_crc_error_flag(ev[0][1]),
        .self_test_error_flag(ev[0][0]),
        .conv3_switch_short_flag(ev[1][6]),
        .conv2_switch_short_flag(ev[1][5]),
        .conv1_switch_short_flag(ev[1][4]), .linreg_short_flag(ev[1][3]),
        .conv3_output_short_flag(ev[1][2]),
        .conv2_output_short_flag(ev[1][1]),
        .conv1_output_short_flag(ev[1][0]),
        .linreg_overvolt_flag(ev[2][3]), .conv3_overvolt_flag(ev[2][2]),
        .conv2_overvolt_flag(ev[2][1]), .conv1_overvolt_flag(ev[2][0]),
        .linreg_undervolt_flag(ev[3][3]), .conv3_undervolt_flag(ev[3][2]),
        .conv2_undervolt_flag(ev[3][1]), .conv1_undervolt_flag(ev[3][0]),
        .linreg_overcurrent_flag(ev[4][6]),
        .conv3_negative_limit_flag(ev[4][5]),
        .conv3_peak_limit_flag(ev[4][4]),
        .conv2_negative_limit_flag(ev[4][3]),
        .conv2_peak_limit_flag(ev[4][2]),
        .conv1_negative_limit_flag(ev[4][1]),
        .conv1_peak_limit_flag(ev[4][0]),
        .sys_err_flags(fl[0]), .short_flags(fl[1]), .ov_mon_flags(fl[2]),
        .uv_mon_flags(fl[3]), .oc_flags(fl[4]));
    ffab_host host_u (.mclk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rd_valid, .reg_wr_done);
    ////////////////////////////////////////////////////////////////////////
    function automatic ffab_byte_t expf(int i, ffab_byte_t v, logic o);
        ffab_byte_t r;
        r = v;
        if (i == 0) begin
            r[0] = v[0] | v[4];
            r[3] = v[3] & o;
        end
        case (i)
            0: return r & USED_SYS_ERR;
            1: return r & USED_SHORT;
            4: return r & USED_OC;
            default: return r & USED_MON;
        endcase
    endfunction
    function automatic ffab_byte_t exps(ffab_byte_t f [5], ffab_byte_t m [5]);
        ffab_byte_t s;
        s = 8'h00;
        s[ST_OC_BIT] = |(f[4] & ~m[4]);
        s[ST_UV_BIT] = |(f[3] & ~m[3]);
        s[ST_OV_BIT] = |(f[2] & ~m[2]);
        s[ST_ERR_BIT] = |((f[0] & ~m[0]) | (f[1] & ~m[1]));
        return s;
    endfunction
    task automatic chk(input ffab_byte_t got, input ffab_byte_t exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input ffab_addr_t a, input ffab_byte_t e);
        ffab_byte_t q;
        host_u.req(1'h0, a, 8'h00, $urandom % 3, q);
        chk(q, e);
    endtask
    task automatic wr(input ffab_addr_t a, input ffab_byte_t d);
        ffab_byte_t q;
        host_u.req(1'h1, a, d, $urandom % 3, q);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Raise events, read back, clear part, then probe refused writes.
    task automatic round(input bit corner);
        ffab_byte_t v [5];
        ffab_byte_t c;
        logic o;
        o = corner ? 1'h0 : 1'($urandom);
        otp <= o;
        for (int i = 0; i < 5; i++) begin
            v[i] = corner ? 8'hFF : 8'($urandom);
            mk[i] <= corner ? 8'h00 : 8'($urandom);
            ev[i] <= v[i];
            xf[i] = xf[i] | expf(i, v[i], o);
        end
        repeat (4) @(posedge mclk);
        foreach (ev[i]) ev[i] <= 8'h00;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            chk(fl[i], xf[i]);
            rdc(OFS_SYS_ERR + 8'(i), xf[i]);
        end
        chk(status_summary, exps(xf, mk));
        rdc(OFS_STATUS, exps(xf, mk));
        for (int i = 0; i < 5; i++) begin
            c = corner ? 8'h00 : 8'($urandom);
            wr(OFS_SYS_ERR + 8'(i), c);
            xf[i] = xf[i] & ~c;
            rdc(OFS_SYS_ERR + 8'(i), xf[i]);
        end
        wr(OFS_STATUS, 8'hFF);
        wr(8'h0A, 8'hFF);
        rdc(8'h0A, 8'h00);
        rdc(OFS_SYS_ERR, xf[0]);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_SYS_ERR + 8'(i), 8'hFF);
            xf[i] = 8'h00;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        rst = 1'h1;
        otp = 1'h0;
        foreach (ev[i]) begin
            ev[i] = 8'h00;
            mk[i] = 8'h00;
            xf[i] = 8'h00;
        end
        void'($urandom(58));
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            rdc(OFS_SYS_ERR + 8'(i), 8'h00);
        end
        rdc(OFS_STATUS, 8'h00);
        round(1'h1);
        repeat (20) round(1'h0);
        ev[0] <= 8'h20;
        repeat (6) @(posedge mclk);
        wr(OFS_SYS_ERR, 8'h20);
        rdc(OFS_SYS_ERR, 8'h20);
        ev[0] <= 8'h00;
        repeat (6) @(posedge mclk);
        rdc(OFS_SYS_ERR, 8'h20);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        rdc(OFS_SYS_ERR, 8'h00);
        results();
    end
endmodule
